// File: rtl/uh_pkg.sv
// Shared constants, register map and state types of the host serial port
package uh_pkg;

	// ****************************************
	// Register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] UH_OFS_DATA = 8'h00;
	localparam logic [7:0] UH_OFS_STATUS = 8'h04;
	localparam logic [7:0] UH_OFS_CTRL = 8'h08;
	localparam logic [7:0] UH_OFS_OS = 8'h0c;
	localparam logic [7:0] UH_OFS_DIV = 8'h10;
	localparam logic [7:0] UH_OFS_TIMEOUT = 8'h14;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int UH_ST_RXV = 0;
	localparam int UH_ST_TXR = 1;
	localparam int UH_ST_TOUT = 2;
	localparam int UH_ST_OVR = 3;
	localparam int UH_ST_FRM = 4;
	localparam int UH_ST_CFG = 5;
	localparam int UH_CT_PIN = 0;
	localparam int UH_CT_RXEN = 1;
	localparam int UH_CT_CLK52 = 2;

	// ****************************************
	// Reset values: 39 MHz, 12 x 28 gives 116071 bit/s
	// ****************************************
	localparam logic [15:0] UH_RST_OS = 16'h000c;
	localparam logic [15:0] UH_RST_DIV = 16'h001c;
	localparam logic UH_RST_CLK52 = 1'h0;
	localparam logic [15:0] UH_RST_TIMEOUT = 16'h0020;

	// ****************************************
	// Bus answers
	// ****************************************
	localparam logic [1:0] UH_RESP_OKAY = 2'h0;
	localparam logic [1:0] UH_RESP_SLVERR = 2'h2;

	// ****************************************
	// Clock and bit rate figures
	// ****************************************
	localparam int UH_CLK_HZ = 200_000_000;
	localparam int UH_SRC39_HZ = 39_000_000;
	localparam int UH_SRC52_HZ = 52_000_000;
	localparam int UH_MAX_BPS = 4_333_333;
	localparam int UH_MIN_BPS = 2400;
	localparam logic [7:0] UH_ACC_MOD = 8'(UH_CLK_HZ / 1_000_000);
	localparam logic [7:0] UH_INC_39 = 8'(UH_SRC39_HZ / 1_000_000);
	localparam logic [7:0] UH_INC_52 = 8'(UH_SRC52_HZ / 1_000_000);
	localparam logic [31:0] UH_MINP_39 = 32'(UH_SRC39_HZ / UH_MAX_BPS);
	localparam logic [31:0] UH_MINP_52 = 32'(UH_SRC52_HZ / UH_MAX_BPS);
	localparam logic [31:0] UH_MAXP_39 = 32'(UH_SRC39_HZ / UH_MIN_BPS);
	localparam logic [31:0] UH_MAXP_52 = 32'(UH_SRC52_HZ / UH_MIN_BPS);

	// ****************************************
	// State types
	// ****************************************
	typedef enum logic [0:0] {UH_TX_IDLE, UH_TX_SEND} uh_tx_e;
	typedef enum logic [1:0] {UH_RX_IDLE, UH_RX_START, UH_RX_DATA, UH_RX_STOP} uh_rx_e;

endpackage

// File: rtl/uh_baud_if.sv
// Carrier between the port logic and its bit rate generator
`timescale 1ns/1ps
interface uh_baud_if;
	logic clk52;
	logic [15:0] div_ratio;
	logic os_tick;
	modport gen (input clk52, input div_ratio, output os_tick);
	modport user (output clk52, output div_ratio, input os_tick);
endinterface

// File: rtl/uh_baud_gen.sv
// Bit rate generator: 39/52 MHz source enable, then the dividing ratio
`timescale 1ns/1ps
module uh_baud_gen
	import uh_pkg::*;
(
	input wire logic clk_in, // 200 MHz clock
	input wire logic reset_n_in, // Async reset, active low
	uh_baud_if.gen bif // Source select, ratio and tick
);
	import uh_pkg::*;

	typedef struct packed {
		logic [7:0] acc;
		logic [15:0] div_cnt;
		logic os_tick;
	} uh_gen_s;

	uh_gen_s st_ff;
	uh_gen_s nxt_st;
	logic [7:0] sum;

	// ****************************************
	// Fractional source and divider
	// ****************************************
	// select source rate
	always_comb begin
		nxt_st = st_ff;
		nxt_st.os_tick = 1'b0;
		sum = st_ff.acc + (bif.clk52 ? UH_INC_52 : UH_INC_39);
		if (sum >= UH_ACC_MOD) begin
			nxt_st.acc = sum - UH_ACC_MOD;
			// ratio divides source
			// Compare with >= so a smaller ratio written mid-count cannot stall
			if (st_ff.div_cnt >= bif.div_ratio - 16'h0001) begin
				nxt_st.div_cnt = 16'h0000;
				nxt_st.os_tick = 1'b1;
			end else begin
				nxt_st.div_cnt = st_ff.div_cnt + 16'h0001;
			end
		end else begin
			nxt_st.acc = sum;
		end
	end

	// State register
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign bif.os_tick = st_ff.os_tick;

	// Source pulses are at most 52 MHz, so two ticks never touch
	chk_tick_spacing: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		st_ff.os_tick |=> !st_ff.os_tick ##1 !st_ff.os_tick)
		else $error("tick faster than source");

endmodule // uh_baud_gen

// File: rtl/uh_host_uart.sv
// Host serial port with hardware flow control behind an AXI4-Lite slave
// How it works
// - Full duplex, start bit, eight data bits LSB first, one stop, no parity.
// - Bit rate settings outside 2400 bit/s to 4.33 Mbit/s are refused.
// - Bit rate is source clock over over-sampling count times dividing ratio.
// - Source clock is selectable, 39 MHz or 52 MHz only.
// - Over-sampling count accepts 1 through 65535 only where its product with the dividing ratio keeps the rate in range.
// - Settings giving more than 4,333,333 bit/s are refused.
// - A new character starts only while clear-to-send is low; characters finish.
// - Receive request output low while a character can be accepted, high otherwise.
// - Flow reaction may lag one to four frames; late characters raise overrun.
// - Timeout flag when gap after a character reaches the preset limit.
// - Overrun flag when a character arrives with the buffer full.
// - Framing error flag when the stop bit is missing.
// - After reset the rate is 39 MHz, 12 by 28, about 116.1 kbit/s.
// - Pins carry the serial function only once software enables them.
`timescale 1ns/1ps
module uh_host_uart
	import uh_pkg::*;
(
	input wire logic clk_in, // 200 MHz clock
	input wire logic reset_n_in, // Async reset, active low
	input wire logic s_axi_awvalid_in, // Write address valid
	output logic s_axi_awready_out, // Write address ready
	input wire logic [7:0] s_axi_awaddr_in, // Write byte address
	input wire logic s_axi_wvalid_in, // Write data valid
	output logic s_axi_wready_out, // Write data ready
	input wire logic [31:0] s_axi_wdata_in, // Write data
	input wire logic [3:0] s_axi_wstrb_in, // Write byte strobes
	output logic s_axi_bvalid_out, // Write response valid
	input wire logic s_axi_bready_in, // Write response ready
	output logic [1:0] s_axi_bresp_out, // Write response
	input wire logic s_axi_arvalid_in, // Read address valid
	output logic s_axi_arready_out, // Read address ready
	input wire logic [7:0] s_axi_araddr_in, // Read byte address
	output logic s_axi_rvalid_out, // Read data valid
	input wire logic s_axi_rready_in, // Read data ready
	output logic [31:0] s_axi_rdata_out, // Read data
	output logic [1:0] s_axi_rresp_out, // Read response
	input wire logic serial_in_pin_in, // Serial data from host
	output logic serial_out_pin_out, // Serial data to host
	input wire logic tx_clear_n_in, // Host ready to take data, low
	output logic rx_flow_request_n_out, // We can take data, low
	output logic uart_pin_sel_out // Pins switched to serial function
);
	import uh_pkg::*;

	typedef struct packed {
		logic awready, wready, bvalid, aw_hold, w_hold;
		logic [1:0] bresp;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic arready, rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic clk52, pin_en, rx_en;
		logic [15:0] os_cnt, div_ratio, to_limit;
		logic rx_s1, rx_s2, rx_prev, cts_s1, cts_s2;
		logic tx_hold_valid;
		logic [7:0] tx_hold;
		uh_tx_e tx_state;
		logic [8:0] tx_shift;
		logic [3:0] tx_bits;
		logic [15:0] tx_tick;
		logic serial_out;
		uh_rx_e rx_state;
		logic [15:0] rx_tick, idle_cnt;
		logic [2:0] rx_bits;
		logic [7:0] rx_shift, rx_buf;
		logic rx_buf_valid, idle_armed;
		logic tout_err, ovr_err, frm_err, cfg_err;
		logic rts_n;
	} uh_top_s;

	uh_top_s st_ff;
	uh_top_s nxt_st;
	uh_baud_if bif ();
	logic wr_fire;

	// ****************************************
	// Helpers
	// ****************************************
	// Byte-lane merge of a 16-bit field
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	function automatic logic rate_ok(input logic c52, input logic [15:0] os,
		input logic [15:0] dv);
		logic [31:0] prod;
		prod = 32'(os) * 32'(dv);
		rate_ok = (os != 16'h0000) && (dv != 16'h0000) &&
			(prod >= (c52 ? UH_MINP_52 : UH_MINP_39)) &&
			(prod <= (c52 ? UH_MAXP_52 : UH_MAXP_39));
	endfunction

	assign wr_fire = st_ff.aw_hold && st_ff.w_hold && !st_ff.bvalid;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		nxt_st = st_ff;
		// Two-stage synchronisers; logic reads stage two, and rx_prev behind it for the receive start edge
		nxt_st.rx_s1 = serial_in_pin_in;
		nxt_st.rx_s2 = st_ff.rx_s1;
		nxt_st.rx_prev = st_ff.rx_s2;
		nxt_st.cts_s1 = tx_clear_n_in;
		nxt_st.cts_s2 = st_ff.cts_s1;

		// Write channels are taken independently, in either order
		if (s_axi_awvalid_in && st_ff.awready) begin
			nxt_st.aw_hold = 1'b1;
			nxt_st.awaddr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && st_ff.wready) begin
			nxt_st.w_hold = 1'b1;
			nxt_st.wdata = s_axi_wdata_in;
			nxt_st.wstrb = s_axi_wstrb_in;
		end
		if (st_ff.bvalid && s_axi_bready_in) begin
			nxt_st.bvalid = 1'b0;
		end

		// Register write once address and data are both held
		if (wr_fire) begin
			nxt_st.aw_hold = 1'b0;
			nxt_st.w_hold = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = UH_RESP_OKAY;
			case ({st_ff.awaddr[7:2], 2'h0})
				UH_OFS_DATA: begin
					// A full holding register drops the byte; software polls ready
					if (st_ff.wstrb[0] && !st_ff.tx_hold_valid) begin
						nxt_st.tx_hold_valid = 1'b1;
						nxt_st.tx_hold = st_ff.wdata[7:0];
					end
				end
				UH_OFS_STATUS: begin
					if (st_ff.wstrb[0]) begin
						nxt_st.tout_err = st_ff.tout_err & ~st_ff.wdata[UH_ST_TOUT];
						nxt_st.ovr_err = st_ff.ovr_err & ~st_ff.wdata[UH_ST_OVR];
						nxt_st.frm_err = st_ff.frm_err & ~st_ff.wdata[UH_ST_FRM];
						nxt_st.cfg_err = st_ff.cfg_err & ~st_ff.wdata[UH_ST_CFG];
					end
				end
				UH_OFS_CTRL: begin
					if (st_ff.wstrb[0]) begin
						nxt_st.pin_en = st_ff.wdata[UH_CT_PIN];
						nxt_st.rx_en = st_ff.wdata[UH_CT_RXEN];
						if (rate_ok(st_ff.wdata[UH_CT_CLK52], st_ff.os_cnt, st_ff.div_ratio)) begin
							nxt_st.clk52 = st_ff.wdata[UH_CT_CLK52];
						end else begin
							nxt_st.cfg_err = 1'b1;
						end
					end
				end
				UH_OFS_OS: begin
					if (rate_ok(st_ff.clk52, merge16(st_ff.os_cnt, st_ff.wdata, st_ff.wstrb),
						st_ff.div_ratio)) begin
						nxt_st.os_cnt = merge16(st_ff.os_cnt, st_ff.wdata, st_ff.wstrb);
					end else begin
						nxt_st.cfg_err = 1'b1;
					end
				end
				UH_OFS_DIV: begin
					if (rate_ok(st_ff.clk52, st_ff.os_cnt,
						merge16(st_ff.div_ratio, st_ff.wdata, st_ff.wstrb))) begin
						nxt_st.div_ratio = merge16(st_ff.div_ratio, st_ff.wdata, st_ff.wstrb);
					end else begin
						nxt_st.cfg_err = 1'b1;
					end
				end
				UH_OFS_TIMEOUT: begin
					nxt_st.to_limit = merge16(st_ff.to_limit, st_ff.wdata, st_ff.wstrb);
				end
				default: begin
					nxt_st.bresp = UH_RESP_SLVERR;
				end
			endcase
		end

		// Read answer one cycle after the address is taken
		if (st_ff.rvalid && s_axi_rready_in) begin
			nxt_st.rvalid = 1'b0;
		end
		if (s_axi_arvalid_in && st_ff.arready) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp = UH_RESP_OKAY;
			case ({s_axi_araddr_in[7:2], 2'h0})
				UH_OFS_DATA: begin
					// Reading the data word pops the receive buffer
					nxt_st.rdata = {24'h000000, st_ff.rx_buf};
					nxt_st.rx_buf_valid = 1'b0;
				end
				UH_OFS_STATUS: nxt_st.rdata = {26'h0, st_ff.cfg_err, st_ff.frm_err,
					st_ff.ovr_err, st_ff.tout_err, !st_ff.tx_hold_valid, st_ff.rx_buf_valid};
				UH_OFS_CTRL: nxt_st.rdata = {29'h0, st_ff.clk52, st_ff.rx_en, st_ff.pin_en};
				UH_OFS_OS: nxt_st.rdata = {16'h0000, st_ff.os_cnt};
				UH_OFS_DIV: nxt_st.rdata = {16'h0000, st_ff.div_ratio};
				UH_OFS_TIMEOUT: nxt_st.rdata = {16'h0000, st_ff.to_limit};
				default: begin
					nxt_st.rdata = 32'h00000000;
					nxt_st.rresp = UH_RESP_SLVERR;
				end
			endcase
		end

		// Transmitter: one bit lasts os_cnt ticks
		case (st_ff.tx_state)
			UH_TX_IDLE: begin
				nxt_st.serial_out = 1'b1;
				// a late clear stops the next character, not the current one
				if (st_ff.pin_en && st_ff.tx_hold_valid && !st_ff.cts_s2) begin
					nxt_st.serial_out = 1'b0;
					nxt_st.tx_shift = {1'b1, st_ff.tx_hold};
					nxt_st.tx_bits = 4'h9;
					nxt_st.tx_tick = 16'h0000;
					nxt_st.tx_hold_valid = 1'b0;
					nxt_st.tx_state = UH_TX_SEND;
				end
			end
			UH_TX_SEND: begin
				if (bif.os_tick) begin
					if (st_ff.tx_tick >= st_ff.os_cnt - 16'h0001) begin
						nxt_st.tx_tick = 16'h0000;
						if (st_ff.tx_bits == 4'h0) begin
							nxt_st.tx_state = UH_TX_IDLE;
						end else begin
							nxt_st.serial_out = st_ff.tx_shift[0];
							nxt_st.tx_shift = {1'b1, st_ff.tx_shift[8:1]};
							nxt_st.tx_bits = st_ff.tx_bits - 4'h1;
						end
					end else begin
						nxt_st.tx_tick = st_ff.tx_tick + 16'h0001;
					end
				end
			end
			default: nxt_st.tx_state = UH_TX_IDLE;
		endcase

		// Receiver
		case (st_ff.rx_state)
			UH_RX_IDLE: begin
				if (bif.os_tick) begin
					if (st_ff.rx_tick >= st_ff.os_cnt - 16'h0001) begin
						nxt_st.rx_tick = 16'h0000;
						if (st_ff.idle_cnt != 16'hffff) begin
							nxt_st.idle_cnt = st_ff.idle_cnt + 16'h0001;
						end
					end else begin
						nxt_st.rx_tick = st_ff.rx_tick + 16'h0001;
					end
				end
				if (st_ff.idle_armed && st_ff.idle_cnt >= st_ff.to_limit) begin
					nxt_st.tout_err = 1'b1;
					nxt_st.idle_armed = 1'b0;
				end
				if (st_ff.pin_en && st_ff.rx_en && st_ff.rx_prev && !st_ff.rx_s2) begin
					nxt_st.rx_tick = 16'h0000;
					nxt_st.rx_state = UH_RX_START;
				end
			end
			UH_RX_START: begin
				if (bif.os_tick) begin
					if (st_ff.rx_tick >= {1'b0, st_ff.os_cnt[15:1]}) begin
						nxt_st.rx_tick = 16'h0000;
						nxt_st.rx_bits = 3'h0;
						nxt_st.rx_state = st_ff.rx_s2 ? UH_RX_IDLE : UH_RX_DATA;
					end else begin
						nxt_st.rx_tick = st_ff.rx_tick + 16'h0001;
					end
				end
			end
			UH_RX_DATA, UH_RX_STOP: begin
				if (bif.os_tick) begin
					if (st_ff.rx_tick >= st_ff.os_cnt - 16'h0001) begin
						nxt_st.rx_tick = 16'h0000;
						if (st_ff.rx_state == UH_RX_DATA) begin
							nxt_st.rx_shift = {st_ff.rx_s2, st_ff.rx_shift[7:1]};
							nxt_st.rx_bits = st_ff.rx_bits + 3'h1;
							if (st_ff.rx_bits == 3'h7) begin
								nxt_st.rx_state = UH_RX_STOP;
							end
						end else begin
							nxt_st.rx_state = UH_RX_IDLE;
							nxt_st.idle_cnt = 16'h0000;
							if (!st_ff.rx_s2) begin
								nxt_st.frm_err = 1'b1;
							end else if (nxt_st.rx_buf_valid) begin
								nxt_st.ovr_err = 1'b1;
								nxt_st.idle_armed = 1'b1;
							end else begin
								nxt_st.rx_buf = st_ff.rx_shift;
								nxt_st.rx_buf_valid = 1'b1;
								nxt_st.idle_armed = 1'b1;
							end
						end
					end else begin
						nxt_st.rx_tick = st_ff.rx_tick + 16'h0001;
					end
				end
			end
			default: nxt_st.rx_state = UH_RX_IDLE;
		endcase

		nxt_st.rts_n = !(nxt_st.pin_en && nxt_st.rx_en && !nxt_st.rx_buf_valid);
		// Ready flags registered from the next state, one transfer at a time
		nxt_st.awready = !nxt_st.aw_hold && !nxt_st.bvalid;
		nxt_st.wready = !nxt_st.w_hold && !nxt_st.bvalid;
		nxt_st.arready = !nxt_st.rvalid;
	end

	// ****************************************
	// State register
	// ****************************************
	// low reset input clears all but ready flags, rate settings, timeout and idle-high lines
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_ff <= '0;
			st_ff.awready <= 1'b1;
			st_ff.wready <= 1'b1;
			st_ff.arready <= 1'b1;
			st_ff.os_cnt <= UH_RST_OS;
			st_ff.div_ratio <= UH_RST_DIV;
			st_ff.clk52 <= UH_RST_CLK52;
			st_ff.to_limit <= UH_RST_TIMEOUT;
			st_ff.rx_s1 <= 1'b1;
			st_ff.rx_s2 <= 1'b1;
			st_ff.rx_prev <= 1'b1;
			st_ff.cts_s1 <= 1'b1;
			st_ff.cts_s2 <= 1'b1;
			st_ff.serial_out <= 1'b1;
			st_ff.rts_n <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************
	// Generator and outputs
	// ****************************************
	assign bif.clk52 = st_ff.clk52;
	assign bif.div_ratio = st_ff.div_ratio;

	uh_baud_gen u_gen (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.bif(bif)
	);

	assign s_axi_awready_out = st_ff.awready;
	assign s_axi_wready_out = st_ff.wready;
	assign s_axi_bvalid_out = st_ff.bvalid;
	assign s_axi_bresp_out = st_ff.bresp;
	assign s_axi_arready_out = st_ff.arready;
	assign s_axi_rvalid_out = st_ff.rvalid;
	assign s_axi_rdata_out = st_ff.rdata;
	assign s_axi_rresp_out = st_ff.rresp;
	// Idle high while the pins still belong to the general purpose function
	assign serial_out_pin_out = st_ff.serial_out;
	assign rx_flow_request_n_out = st_ff.rts_n;
	assign uart_pin_sel_out = st_ff.pin_en;

	// ****************************************
	// Checks
	// ****************************************
	chk_tx_clear_gate: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(st_ff.tx_state == UH_TX_IDLE) ##1 (st_ff.tx_state == UH_TX_SEND) |->
		!$past(st_ff.cts_s2) && !st_ff.serial_out)
		else $error("character started without clear");
	chk_tx_stop_high: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(st_ff.tx_state == UH_TX_SEND) ##1 (st_ff.tx_state == UH_TX_IDLE) |->
		$past(st_ff.serial_out) && $past(st_ff.tx_bits) == 4'h0)
		else $error("frame ended without stop bit");
	chk_rts_full_high: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		$rose(st_ff.rx_buf_valid) |-> st_ff.rts_n ##1 (st_ff.rts_n || !st_ff.rx_buf_valid))
		else $error("request low with buffer full");
	chk_overrun_cause: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		$rose(st_ff.ovr_err) |-> $past(st_ff.rx_buf_valid) && st_ff.rx_buf_valid)
		else $error("overrun without full buffer");
	chk_frame_cause: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		$rose(st_ff.frm_err) |-> $past(st_ff.rx_state) == UH_RX_STOP && !$past(st_ff.rx_s2))
		else $error("framing error without low stop");
	chk_timeout_cause: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		$rose(st_ff.tout_err) |-> $past(st_ff.idle_cnt) >= $past(st_ff.to_limit))
		else $error("timeout before limit");
	chk_rate_ceiling: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		32'(st_ff.os_cnt) * 32'(st_ff.div_ratio) >= (st_ff.clk52 ? UH_MINP_52 : UH_MINP_39))
		else $error("bit rate above ceiling");
	chk_rate_floor: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		32'(st_ff.os_cnt) * 32'(st_ff.div_ratio) <= (st_ff.clk52 ? UH_MAXP_52 : UH_MAXP_39))
		else $error("bit rate below floor");
	chk_flag_sticky: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		st_ff.frm_err && !wr_fire |=> st_ff.frm_err)
		else $error("error flag dropped without clear");
	chk_start_centre: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(st_ff.rx_state == UH_RX_START) ##1 (st_ff.rx_state == UH_RX_DATA) |->
		$past(st_ff.rx_tick) >= {1'b0, $past(st_ff.os_cnt[15:1])})
		else $error("start accepted before mid-bit");

endmodule // uh_host_uart

// File: verif/uh_host_model.sv
// Host partner: serial sender and receiver at a fixed bit time
`timescale 1ns/1ps
module uh_host_model #(
	parameter real BIT_NS = 230.769
) (
	input wire logic line_in, // From device transmitter
	output logic line_out // To device receiver
);
	logic [7:0] rxq[$];
	logic [7:0] sh;

	initial line_out = 1'h1;

	// whole frame, LSB first; flow request is not watched, as a late host may do
	task automatic send(input logic [7:0] b, input logic stop);
		line_out = 1'h0;
		#(BIT_NS);
		for (int i = 0; i < 8; i++) begin
			line_out = b[i];
			#(BIT_NS);
		end
		line_out = stop;
		#(BIT_NS);
		line_out = 1'h1; // Idle level between frames
		#(BIT_NS);
	endtask

	// capture at mid-bit; only frames with a high stop bit are kept
	always begin
		@(negedge line_in);
		#(BIT_NS * 1.5);
		for (int i = 0; i < 8; i++) begin
			sh[i] = line_in;
			#(BIT_NS);
		end
		if (line_in === 1'h1) rxq.push_back(sh);
	end
endmodule // uh_host_model

// File: verif/host_uart_flow_ctrl_bench.sv
// Self-checking bench of the host serial port
`timescale 1ns/1ps
module host_uart_flow_ctrl_bench;
	import uh_pkg::*;
	logic clk, rst_n, awv, wv, bvr, arv, rr, cts_n, sin;
	logic awr, wrdy, bv, arr, rv, sout, rts_n, psel;
	logic [7:0] awa, ara;
	logic [31:0] wd, rd, q;
	logic [3:0] ws;
	logic [1:0] br, rrsp, resp;
	int fails, n_checks;

	uh_host_uart uut (.clk_in(clk), .reset_n_in(rst_n), .s_axi_awvalid_in(awv),
		.s_axi_awready_out(awr), .s_axi_awaddr_in(awa), .s_axi_wvalid_in(wv),
		.s_axi_wready_out(wrdy), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws),
		.s_axi_bvalid_out(bv), .s_axi_bready_in(bvr), .s_axi_bresp_out(br),
		.s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_araddr_in(ara),
		.s_axi_rvalid_out(rv), .s_axi_rready_in(rr), .s_axi_rdata_out(rd),
		.s_axi_rresp_out(rrsp), .serial_in_pin_in(sin), .serial_out_pin_out(sout),
		.tx_clear_n_in(cts_n), .rx_flow_request_n_out(rts_n), .uart_pin_sel_out(psel));
	uh_host_model host (.line_in(sout), .line_out(sin));

	// Clock, 5 ns period
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Bus write; handshakes judged at the rising edge, before its updates land
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		awa <= a;
		wd <= d;
		ws <= 4'hf;
		awv <= 1'h1;
		wv <= 1'h1;
		bvr <= 1'h1;
		for (int n = 0; n < 40; n++) begin
			@(posedge clk);
			if (awv && awr) awv <= 1'h0;
			if (wv && wrdy) wv <= 1'h0;
			if (bv && bvr) begin
				resp = br;
				bvr <= 1'h0;
				return;
			end
		end
		fails++;
	endtask

	// Bus read; data taken at the edge where rvalid and rready meet
	task automatic axr(input logic [7:0] a);
		ara <= a;
		arv <= 1'h1;
		rr <= 1'h1;
		for (int n = 0; n < 40; n++) begin
			@(posedge clk);
			if (arv && arr) arv <= 1'h0;
			if (rv && rr) begin
				q = rd;
				resp = rrsp;
				rr <= 1'h0;
				return;
			end
		end
		fails++;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		axr(a);
		chk(q & m, e);
	endtask

	// Wait for a byte at the host, bounded
	task automatic getb(input logic [7:0] e);
		for (int n = 0; n < 3000 && host.rxq.size() == 0; n++) @(posedge clk);
		if (host.rxq.size() == 0) chk(32'h100, 32'(e));
		else chk(32'(host.rxq.pop_front()), 32'(e));
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// Watchdog, well past the expected 6k cycles
	initial begin
		repeat (60000) @(posedge clk);
		fails++;
		results();
	end

	// Main sequence
	initial begin
		{awv, wv, bvr, arv, rr, awa, ara, wd, ws} = '0;
		cts_n = 1'h1;
		rst_n = 1'h0;
		repeat (20) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		rdc(UH_OFS_OS, 32'hffff, 32'h000c);
		rdc(UH_OFS_DIV, 32'hffff, 32'h001c);
		rdc(UH_OFS_CTRL, 32'h7, 32'h0);
		rdc(UH_OFS_TIMEOUT, 32'hffff, 32'h0020);
		chk(32'({psel, sout, rts_n}), 32'h3);
		axr(8'h18);
		chk(32'(resp), 32'(UH_RESP_SLVERR));
		axw(8'h18, 32'h0);
		chk(32'(resp), 32'(UH_RESP_SLVERR));
		// Fastest rate: 52 MHz, 12 x 1
		axw(UH_OFS_CTRL, 32'h7);
		axw(UH_OFS_DIV, 32'h1);
		rdc(UH_OFS_DIV, 32'hffff, 32'h1);
		chk(32'({psel, rts_n}), 32'h2);
		axw(UH_OFS_OS, 32'hb);
		rdc(UH_OFS_STATUS, 32'h20, 32'h20);
		axw(UH_OFS_OS, 32'h0);
		rdc(UH_OFS_OS, 32'hffff, 32'h000c);
		axw(UH_OFS_STATUS, 32'h20);
		rdc(UH_OFS_STATUS, 32'h20, 32'h0);
		// Transmit and clear-to-send
		cts_n <= 1'h0;
		axw(UH_OFS_DATA, 32'ha5);
		getb(8'ha5);
		cts_n <= 1'h1;
		axw(UH_OFS_DATA, 32'h3c);
		repeat (1000) @(posedge clk);
		chk(32'(host.rxq.size()), 32'h0);
		cts_n <= 1'h0;
		repeat (150) @(posedge clk);
		cts_n <= 1'h1;
		getb(8'h3c);
		// Receive, flow request and timeout
		host.send(8'h5a, 1'h1);
		repeat (20) @(posedge clk);
		chk(32'(rts_n), 32'h1);
		rdc(UH_OFS_STATUS, 32'h1d, 32'h1);
		rdc(UH_OFS_DATA, 32'hff, 32'h5a);
		chk(32'(rts_n), 32'h0);
		rdc(UH_OFS_STATUS, 32'h4, 32'h0);
		repeat (2000) @(posedge clk);
		rdc(UH_OFS_STATUS, 32'h4, 32'h4);
		// Overrun, sticky until cleared
		host.send(8'h11, 1'h1);
		host.send(8'h22, 1'h1);
		repeat (20) @(posedge clk);
		rdc(UH_OFS_STATUS, 32'h8, 32'h8);
		rdc(UH_OFS_DATA, 32'hff, 32'h11);
		rdc(UH_OFS_STATUS, 32'h8, 32'h8);
		axw(UH_OFS_STATUS, 32'h8);
		rdc(UH_OFS_STATUS, 32'h8, 32'h0);
		// Missing stop bit
		host.send(8'h33, 1'h0);
		repeat (20) @(posedge clk);
		rdc(UH_OFS_STATUS, 32'h11, 32'h10);
		results();
	end
endmodule // host_uart_flow_ctrl_bench
